// file: hdl/sdlbp_pkg.sv
package sdlbp_pkg;
	// Bus and frame geometry
	localparam int DATA_W      = 16;
	localparam int CFG_W       = 3;
	localparam int FRAME_W     = 22;
	localparam int FRAME_PAIRS = 11;
	localparam int REPLY_PAIRS = 8;
	localparam int SYNC_W      = 30;
	// Frame field positions
	localparam int F_PRI = 19;
	localparam int F_SEC = 18;
	localparam int F_CD  = 17;
	localparam int F_DIR = 16;
	// Lane symbols
	localparam logic [1:0] LANE_START = 2'h0;
	localparam logic [1:0] LANE_IDLE  = 2'h3;
	// Timing, figures in ns, counts derived from the clock period
	localparam int CLK_PERIOD_NS  = 40;
	localparam int LANE_PERIOD_NS = 320;
	localparam int LANE_HALF_CYC  = LANE_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int STROBE_NS      = 160;
	localparam int STROBE_CYC     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_NS        = 2560;
	localparam int IDLE_CYC       = IDLE_NS / CLK_PERIOD_NS;
	// Reset values of the synchronised pins: selects and strobes idle high, lanes idle
	localparam logic [SYNC_W-1:0] SYNC_INIT = 30'h07800030;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SEND,
		ST_WAIT,
		ST_TAKE,
		ST_RECV,
		ST_REPLAY,
		ST_RETURN
	} sdlbp_state_t;
endpackage

// file: hdl/sdlbp_sync.sv
`timescale 1ns/1ps
module sdlbp_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sdlbp_sync_t;

	sdlbp_sync_t r;
	sdlbp_sync_t next_r;

	// First stage feeds only the second
	always_comb begin
		next_r    = r;
		next_r.s1 = d;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= {INIT, INIT};
		end else begin
			r <= next_r;
		end
	end

	assign q = r.s2;
endmodule

// file: hdl/sdlbp_bus_port.sv
`timescale 1ns/1ps
// Behaviour
// - Role pin high makes the host end, low the display end.
// - Style pin high selects strobe pair, low enable plus direction.
// - Host end: sleep input low powers down lanes and lane clock.
// - Display end: sleep pin output high while link active, low asleep.
// - Display end holds enable output high in enable style.
// - Host: read strobe active low; read data driven while strobe and select low and the interrupt is set.
// - Display end drives read and write strobes active low.
// - Direction high means read, low means write, on both ends.
// - Host captures write data when write strobe or select rises first.
// - Two active-low selects address primary and secondary display.
// - Command/data select: high data, low command; reproduced at display end.
// - Host interrupt rises when read data ready, drops on second read.
// - Display end outputs a frequency reference clock only.
// - Config input sets host lane clock and display divisor.
// - Host drives lane clock; both ends drive and receive data lanes.
module sdlbp_bus_port (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        role_host,
	input  wire logic        bus_style_strobe,
	input  wire logic        link_sleep_n_in,
	output logic             link_sleep_n_out,
	output logic             link_sleep_n_oe,
	input  wire logic        multi_fn_zero_in,
	output logic             multi_fn_zero_out,
	output logic             multi_fn_zero_oe,
	input  wire logic        multi_fn_one_in,
	output logic             multi_fn_one_out,
	output logic             multi_fn_one_oe,
	input  wire logic        primary_select_n_in,
	output logic             primary_select_n_out,
	output logic             primary_select_n_oe,
	input  wire logic        secondary_select_n_in,
	output logic             secondary_select_n_out,
	output logic             secondary_select_n_oe,
	input  wire logic        cmd_data_in,
	output logic             cmd_data_out,
	output logic             cmd_data_oe,
	input  wire logic [15:0] data_in,
	output logic      [15:0] data_out,
	output logic             data_oe,
	output logic             read_ready_irq,
	output logic             ref_clk_out,
	output logic             ref_clk_oe,
	input  wire logic [2:0]  synth_cfg,
	input  wire logic [1:0]  serial_lanes_in,
	output logic      [1:0]  serial_lanes_out,
	output logic             serial_lanes_oe,
	input  wire logic        serial_lane_clock_in,
	output logic             serial_lane_clock_out,
	output logic             serial_lane_clock_oe
);
	typedef struct packed {
		sdlbp_pkg::sdlbp_state_t st;
		logic [4:0]  div;
		logic [4:0]  cnt;
		logic [6:0]  act;
		logic [2:0]  refdiv;
		logic [21:0] sr;
		logic [15:0] rdata;
		logic [15:0] d_hold;
		logic [2:0]  hdr_hold;
		logic        is_read;
		logic        wr_prev;
		logic        rd_prev;
		logic        lclk_prev;
		logic        irq;
		logic        lclk;
		logic        lclk_oe;
		logic [1:0]  lanes;
		logic        lanes_oe;
		logic [15:0] bus;
		logic        bus_oe;
		logic        mf0;
		logic        mf1;
		logic        pri;
		logic        sec;
		logic        cd;
		logic        pins_oe;
		logic        sleep_o;
		logic        sleep_oe;
		logic        refclk;
		logic        refclk_oe;
	} sdlbp_core_t;

	localparam logic [6:0] IDLE_LIM = 7'(sdlbp_pkg::IDLE_CYC);

	sdlbp_core_t r;
	sdlbp_core_t next_r;
	logic [29:0] sync_q;
	logic        host, style, awake, s_mf0, s_mf1, s_pri, s_sec, s_cd, s_lclk;
	logic [15:0] s_data;
	logic [1:0]  s_lanes;
	logic [2:0]  s_cfg;
	logic        cs_low, rd_act, wr_act, rd_end, wr_end;
	logic        rise_own, fall_own, rise_rx, fall_rx, rx_dir;
	logic [4:0]  half;
	logic [21:0] frame_in;

	// Every pin from outside passes two flops before use
	sdlbp_sync #(
		.W    (sdlbp_pkg::SYNC_W),
		.INIT (sdlbp_pkg::SYNC_INIT)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({role_host, bus_style_strobe, link_sleep_n_in, multi_fn_zero_in,
			multi_fn_one_in, primary_select_n_in, secondary_select_n_in, cmd_data_in,
			data_in, serial_lanes_in, serial_lane_clock_in, synth_cfg}),
		.q   (sync_q)
	);

	assign {host, style, awake, s_mf0, s_mf1, s_pri, s_sec, s_cd,
		s_data, s_lanes, s_lclk, s_cfg} = sync_q;

	// Cycle decode shared by both bus styles
	assign cs_low   = ~s_pri | ~s_sec;
	assign rd_act   = style ? (~s_mf0 & cs_low) : (s_mf0 & cs_low & s_mf1);
	assign wr_act   = style ? (~s_mf1 & cs_low) : (s_mf0 & cs_low & ~s_mf1);
	assign rd_end   = r.rd_prev & ~rd_act;
	assign wr_end   = r.wr_prev & ~wr_act;
	assign rise_rx  = s_lclk & ~r.lclk_prev;
	assign fall_rx  = ~s_lclk & r.lclk_prev;
	assign half     = 5'(sdlbp_pkg::LANE_HALF_CYC) + {2'h0, s_cfg};
	assign rise_own = host & awake & (r.div >= half - 5'h01) & ~r.lclk;
	assign fall_own = host & awake & (r.div >= half - 5'h01) & r.lclk;
	assign frame_in = {r.sr[19:0], s_lanes};
	assign rx_dir   = frame_in[sdlbp_pkg::F_DIR];

	always_comb begin
		next_r           = r;
		next_r.wr_prev   = wr_act;
		next_r.rd_prev   = rd_act;
		next_r.lclk_prev = s_lclk;
		// Pin directions follow the role
		next_r.pins_oe   = ~host;
		next_r.sleep_oe  = ~host;
		next_r.refclk_oe = ~host;
		next_r.lclk_oe   = host & awake;
		if (host) begin
			next_r.irq = r.irq;
			next_r.bus = r.rdata;
			next_r.bus_oe = r.irq & rd_act;
			if (wr_act | rd_act) begin
				next_r.d_hold   = s_data;
				next_r.hdr_hold = {s_pri, s_sec, s_cd};
			end
			if (!awake) begin
				next_r.st       = sdlbp_pkg::ST_IDLE;
				next_r.lclk     = 1'b0;
				next_r.lanes_oe = 1'b0;
				next_r.div      = 5'h00;
			end else begin
				// Lane clock divider; a larger setting only slows the link
				if (r.div >= half - 5'h01) begin
					next_r.div  = 5'h00;
					next_r.lclk = ~r.lclk;
				end else begin
					next_r.div = r.div + 5'h01;
				end
				if (wr_end && r.st == sdlbp_pkg::ST_IDLE) begin
					next_r.sr      = {2'h0, r.hdr_hold, 1'b0, r.d_hold};
					next_r.is_read = 1'b0;
					next_r.st      = sdlbp_pkg::ST_SEND;
					next_r.cnt     = 5'h00;
				end
				if (rd_end) begin
					if (r.irq) begin
						next_r.irq = 1'b0;
					end else if (r.st == sdlbp_pkg::ST_IDLE) begin
						next_r.sr      = {2'h0, r.hdr_hold, 1'b1, 16'h0000};
						next_r.is_read = 1'b1;
						next_r.st      = sdlbp_pkg::ST_SEND;
						next_r.cnt     = 5'h00;
					end
				end
				case (r.st)
					sdlbp_pkg::ST_IDLE: begin
						// Retake the lanes only on a rising edge, after the far end let go
						if (rise_own) begin
							next_r.lanes_oe = 1'b1;
							next_r.lanes    = sdlbp_pkg::LANE_IDLE;
						end
					end
					sdlbp_pkg::ST_SEND: begin
						if (fall_own) begin
							next_r.cnt = r.cnt + 5'h01;
							if (r.cnt == 5'h00) begin
								next_r.lanes = sdlbp_pkg::LANE_START;
							end else if (r.cnt <= 5'(sdlbp_pkg::FRAME_PAIRS)) begin
								next_r.lanes = r.sr[21:20];
								next_r.sr    = {r.sr[19:0], 2'h0};
							end else if (r.is_read) begin
								next_r.st       = sdlbp_pkg::ST_WAIT;
								next_r.lanes_oe = 1'b0;
							end else begin
								next_r.st    = sdlbp_pkg::ST_IDLE;
								next_r.lanes = sdlbp_pkg::LANE_IDLE;
							end
						end
					end
					sdlbp_pkg::ST_WAIT: begin
						if (fall_own && s_lanes == sdlbp_pkg::LANE_START) begin
							next_r.st  = sdlbp_pkg::ST_TAKE;
							next_r.cnt = 5'h00;
						end
					end
					sdlbp_pkg::ST_TAKE: begin
						if (fall_own) begin
							next_r.rdata = {r.rdata[13:0], s_lanes};
							next_r.cnt   = r.cnt + 5'h01;
							if (r.cnt == 5'(sdlbp_pkg::REPLY_PAIRS - 1)) begin
								next_r.irq = 1'b1;
								next_r.st  = sdlbp_pkg::ST_IDLE;
							end
						end
					end
					default: begin
						next_r.st = sdlbp_pkg::ST_IDLE;
					end
				endcase
			end
		end else begin
			next_r.irq  = 1'b0;
			next_r.lclk = 1'b0;
			// Link counted asleep once the lane clock stops
			next_r.act  = rise_rx ? 7'h00 : ((r.act == IDLE_LIM) ? r.act : r.act + 7'h01);
			next_r.sleep_o = (r.act != IDLE_LIM);
			// Reference clock divides by twice the setting plus two
			if (r.refdiv >= s_cfg) begin
				next_r.refdiv = 3'h0;
				next_r.refclk = ~r.refclk;
			end else begin
				next_r.refdiv = r.refdiv + 3'h1;
			end
			case (r.st)
				sdlbp_pkg::ST_RECV: begin
					if (r.act == IDLE_LIM) begin
						next_r.st = sdlbp_pkg::ST_IDLE;
					end else if (rise_rx) begin
						next_r.sr  = frame_in;
						next_r.cnt = r.cnt + 5'h01;
						if (r.cnt == 5'(sdlbp_pkg::FRAME_PAIRS - 1)) begin
							next_r.st      = sdlbp_pkg::ST_REPLAY;
							next_r.cnt     = 5'h00;
							next_r.is_read = rx_dir;
							next_r.pri     = frame_in[sdlbp_pkg::F_PRI];
							next_r.sec     = frame_in[sdlbp_pkg::F_SEC];
							next_r.cd      = frame_in[sdlbp_pkg::F_CD];
							next_r.mf0     = style ? ~rx_dir : 1'b1;
							next_r.mf1     = rx_dir;
							next_r.bus     = frame_in[15:0];
							next_r.bus_oe  = ~rx_dir;
						end
					end
				end
				sdlbp_pkg::ST_REPLAY: begin
					next_r.cnt = r.cnt + 5'h01;
					// Selects and strobes rise together: the display captures on that edge
					if (r.cnt == 5'(sdlbp_pkg::STROBE_CYC - 1)) begin
						next_r.pri    = 1'b1;
						next_r.sec    = 1'b1;
						next_r.mf0    = 1'b1;
						next_r.mf1    = 1'b1;
						next_r.bus_oe = 1'b0;
						next_r.cnt    = 5'h00;
						if (r.is_read) begin
							next_r.sr[15:0] = s_data;
							next_r.st       = sdlbp_pkg::ST_RETURN;
						end else begin
							next_r.st = sdlbp_pkg::ST_IDLE;
						end
					end
				end
				sdlbp_pkg::ST_RETURN: begin
					if (r.act == IDLE_LIM) begin
						next_r.st       = sdlbp_pkg::ST_IDLE;
						next_r.lanes_oe = 1'b0;
					end else if (fall_rx) begin
						next_r.cnt = r.cnt + 5'h01;
						if (r.cnt == 5'h00) begin
							next_r.lanes_oe = 1'b1;
							next_r.lanes    = sdlbp_pkg::LANE_START;
						end else if (r.cnt <= 5'(sdlbp_pkg::REPLY_PAIRS)) begin
							next_r.lanes = r.sr[15:14];
							next_r.sr    = {r.sr[19:0], 2'h0};
						end else begin
							next_r.lanes_oe = 1'b0;
							next_r.st       = sdlbp_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					next_r.lanes_oe = 1'b0;
					next_r.st       = sdlbp_pkg::ST_IDLE;
					if (rise_rx && s_lanes == sdlbp_pkg::LANE_START) begin
						next_r.st  = sdlbp_pkg::ST_RECV;
						next_r.cnt = 5'h00;
					end
				end
			endcase
		end
	end

	// Idle bus: selects and strobes high, nothing driven
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r     <= '0;
			r.st  <= sdlbp_pkg::ST_IDLE;
			r.mf0 <= 1'b1;
			r.mf1 <= 1'b1;
			r.pri <= 1'b1;
			r.sec <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign link_sleep_n_out       = r.sleep_o;
	assign link_sleep_n_oe        = r.sleep_oe;
	assign multi_fn_zero_out      = r.mf0;
	assign multi_fn_zero_oe       = r.pins_oe;
	assign multi_fn_one_out       = r.mf1;
	assign multi_fn_one_oe        = r.pins_oe;
	assign primary_select_n_out   = r.pri;
	assign primary_select_n_oe    = r.pins_oe;
	assign secondary_select_n_out = r.sec;
	assign secondary_select_n_oe  = r.pins_oe;
	assign cmd_data_out           = r.cd;
	assign cmd_data_oe            = r.pins_oe;
	assign data_out               = r.bus;
	assign data_oe                = r.bus_oe;
	assign read_ready_irq         = r.irq;
	assign ref_clk_out            = r.refclk;
	assign ref_clk_oe             = r.refclk_oe;
	assign serial_lanes_out       = r.lanes;
	assign serial_lanes_oe        = r.lanes_oe;
	assign serial_lane_clock_out  = r.lclk;
	assign serial_lane_clock_oe   = r.lclk_oe;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_host_lane_clk: assert property (host && awake |=> serial_lane_clock_oe)
		else $error("host end not driving lane clock");
	a_sleep_lanes_off: assert property (host && !awake |=>
		!serial_lanes_oe && !serial_lane_clock_oe)
		else $error("lanes still driven in sleep");
	a_disp_sleep_lvl: assert property (!host && r.act == IDLE_LIM |=>
		link_sleep_n_oe && !link_sleep_n_out)
		else $error("display sleep output wrong");
	a_enable_static: assert property (!host && !style &&
		r.st == sdlbp_pkg::ST_REPLAY |=> multi_fn_zero_out)
		else $error("enable output not held high");
	a_read_drive: assert property (host && data_oe |-> $past(rd_act) && $past(r.irq))
		else $error("read data driven outside read cycle");
	a_irq_drop: assert property (host && awake && r.irq && rd_end |=> !read_ready_irq)
		else $error("interrupt not dropped on second read");
	a_write_send: assert property (host && awake && wr_end &&
		r.st == sdlbp_pkg::ST_IDLE |=> r.st == sdlbp_pkg::ST_SEND && r.cnt == 5'h00)
		else $error("write end did not start a frame");
	a_disp_dir: assert property (!host && rise_rx && r.st == sdlbp_pkg::ST_RECV &&
		r.cnt == 5'h0a |=> multi_fn_one_out == $past(rx_dir))
		else $error("direction output wrong");
	a_disp_irq_low: assert property (!host |=> !read_ready_irq)
		else $error("interrupt raised on display end");
	a_ref_toggle: assert property (!host ##1 !host |-> ##[1:20] $changed(ref_clk_out))
		else $error("reference clock stalled");

	c_write_frame: cover property (host && wr_end && r.st == sdlbp_pkg::ST_IDLE);
	c_read_ready: cover property (host && $rose(read_ready_irq));
	c_disp_replay: cover property (!host && r.st == sdlbp_pkg::ST_REPLAY && r.is_read);
endmodule

// file: tb/sdlbp_link_peer.sv
`timescale 1ns/1ps
// Display-end stand-in: takes host frames on lane clock rises, answers reads
module sdlbp_link_peer (
	input  wire logic        lclk,
	input  wire logic [1:0]  lanes,
	input  wire logic [15:0] reply,
	input  wire logic [3:0]  gap,
	output logic      [1:0]  drive,
	output logic             drive_en,
	output logic      [21:0] frame,
	output int               frames
);
	int cnt = 0;
	int rcnt = 0;
	int pend = 0;

	// Quiet start: lanes released, nothing collected
	initial begin
		drive = 2'h3;
		drive_en = 1'b0;
		frame = 22'h000000;
		frames = 0;
	end

	// Host launches on falls, so rises sit mid-bit; gap models a slow far end
	always @(posedge lclk) begin : peer_seq
		logic [21:0] nf;
		nf = {frame[19:0], lanes};
		if (rcnt > 0) begin
			drive <= reply[2*rcnt-1 -: 2];
			rcnt <= rcnt - 1;
		end else if (drive_en)
			drive_en <= 1'b0;
		else if (pend > 1)
			pend <= pend - 1;
		else if (pend == 1) begin
			drive <= 2'h0;
			drive_en <= 1'b1;
			rcnt <= 8;
			pend <= 0;
		end else if (cnt > 0) begin
			frame <= nf;
			cnt <= cnt - 1;
			if (cnt == 1) begin
				frames <= frames + 1;
				pend <= nf[sdlbp_pkg::F_DIR] ? 1 + gap : 0;
			end
		end else if (lanes == 2'h0)
			cnt <= 11;
	end
endmodule

// file: tb/test_serial_display_link_bus_port.sv
`timescale 1ns/1ps
// Both roles; a link peer stands in for the display end, the bench for the host end
module test_serial_display_link_bus_port;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        role_host = 1'b1;
	logic        bus_style_strobe = 1'b1;
	logic        link_sleep_n_in = 1'b1;
	logic        multi_fn_zero_in = 1'b1;
	logic        multi_fn_one_in = 1'b1;
	logic        primary_select_n_in = 1'b1;
	logic        secondary_select_n_in = 1'b1;
	logic        cmd_data_in = 1'b0;
	logic [15:0] cpu_data = 16'h0000;
	logic [2:0]  synth_cfg = 3'h0;
	logic [15:0] reply = 16'h0000;
	logic [3:0]  gap = 4'h0;
	logic        link_sleep_n_out, link_sleep_n_oe, multi_fn_zero_out, multi_fn_zero_oe;
	logic        multi_fn_one_out, multi_fn_one_oe, primary_select_n_out, primary_select_n_oe;
	logic        secondary_select_n_out, secondary_select_n_oe, cmd_data_out, cmd_data_oe;
	logic        data_oe, read_ready_irq, ref_clk_out, ref_clk_oe, serial_lanes_oe;
	logic        serial_lane_clock_out, serial_lane_clock_oe;
	logic [15:0] data_out;
	logic [1:0]  serial_lanes_out;
	wire  [1:0]  serial_lanes_in;
	wire         serial_lane_clock_in;
	wire  [15:0] data_in;
	logic [1:0]  p_drive;
	logic        p_en;
	logic [21:0] p_frame;
	int          p_frames;
	int          err_total = 0;
	int          total_checks = 0;
	logic [20:0] exp_q[$];
	logic [20:0] e;
	logic        b_lclk = 1'b0;
	logic [1:0]  b_lanes = 2'h3;
	logic [15:0] rx_w = 16'h0000;
	int          rx_n = 0;

	// Wire levels from every party's enable; released lanes sit at idle
	assign serial_lanes_in = serial_lanes_oe ? serial_lanes_out : (p_en ? p_drive : b_lanes);
	assign serial_lane_clock_in = serial_lane_clock_oe ? serial_lane_clock_out : b_lclk;
	assign data_in = data_oe ? data_out : cpu_data;

	// 25 MHz core clock
	always #20 clk = ~clk;

	sdlbp_bus_port dut (.clk, .rst, .role_host, .bus_style_strobe, .link_sleep_n_in,
		.link_sleep_n_out, .link_sleep_n_oe, .multi_fn_zero_in, .multi_fn_zero_out,
		.multi_fn_zero_oe, .multi_fn_one_in, .multi_fn_one_out, .multi_fn_one_oe,
		.primary_select_n_in, .primary_select_n_out, .primary_select_n_oe,
		.secondary_select_n_in, .secondary_select_n_out, .secondary_select_n_oe,
		.cmd_data_in, .cmd_data_out, .cmd_data_oe, .data_in, .data_out, .data_oe,
		.read_ready_irq, .ref_clk_out, .ref_clk_oe, .synth_cfg, .serial_lanes_in,
		.serial_lanes_out, .serial_lanes_oe, .serial_lane_clock_in,
		.serial_lane_clock_out, .serial_lane_clock_oe);

	// Peer hears only the host's own lane clock, never the bench's
	sdlbp_link_peer peer (.lclk(serial_lane_clock_oe & serial_lane_clock_out),
		.lanes(serial_lanes_in), .reply, .gap, .drive(p_drive), .drive_en(p_en),
		.frame(p_frame), .frames(p_frames));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (err_total == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Model: each delivered frame against the oldest expectation, read data masked
	always @(p_frames) begin
		#1;
		if (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			check({p_frame[sdlbp_pkg::F_PRI], p_frame[sdlbp_pkg::F_SEC],
				p_frame[sdlbp_pkg::F_CD], p_frame[sdlbp_pkg::F_DIR],
				e[20] ? 16'h0000 : p_frame[15:0]}, e[19:0]);
		end
	end

	// One CPU cycle in the current style; strobe style: select rises before the strobe, enable style: enable drops before the select rises
	task automatic cpu_cycle(input logic rd, input logic sec, input logic cd,
		input logic [15:0] d, input logic fetch);
		@(posedge clk);
		primary_select_n_in <= sec;
		secondary_select_n_in <= !sec;
		cmd_data_in <= cd;
		cpu_data <= d;
		multi_fn_zero_in <= bus_style_strobe ? !rd : 1'b1;
		multi_fn_one_in <= rd;
		repeat (6) @(posedge clk);
		if (fetch) begin
			check(data_oe, 1'b1);
			check(data_out, reply);
		end
		if (bus_style_strobe) begin
			primary_select_n_in <= 1'b1;
			secondary_select_n_in <= 1'b1;
		end else
			multi_fn_zero_in <= 1'b0;
		@(posedge clk);
		primary_select_n_in <= 1'b1;
		secondary_select_n_in <= 1'b1;
		multi_fn_zero_in <= bus_style_strobe;
		multi_fn_one_in <= 1'b1;
	endtask

	task automatic cpu_write(input logic sec, input logic cd, input logic [15:0] d);
		int n;
		int k;
		n = p_frames;
		exp_q.push_back({1'b0, sec, !sec, cd, 1'b0, d});
		cpu_cycle(1'b0, sec, cd, d, 1'b0);
		for (k = 0; k < 400 && p_frames == n; k++) @(posedge clk);
		check(p_frames - n, 1);
		repeat (40) @(posedge clk);
	endtask

	// Request, wait for the interrupt, then fetch with a second read
	task automatic cpu_read(input logic sec);
		int k;
		reply <= 16'($urandom);
		gap <= sec ? 4'h5 : 4'h0;
		exp_q.push_back({1'b1, sec, !sec, 1'b1, 1'b1, 16'h0000});
		cpu_cycle(1'b1, sec, 1'b1, 16'h0000, 1'b0);
		for (k = 0; k < 1000 && read_ready_irq !== 1'b1; k++) @(posedge clk);
		check(read_ready_irq, 1'b1);
		cpu_cycle(1'b1, sec, 1'b1, 16'h0000, 1'b1);
		repeat (6) @(posedge clk);
		check(read_ready_irq, 1'b0);
		repeat (600) @(posedge clk);
	endtask

	// One lane period as a host end makes it; the reply is taken just before the rise
	task automatic lane_tick(input logic [1:0] v);
		b_lanes <= v;
		b_lclk <= 1'b0;
		repeat (4) @(posedge clk);
		if (serial_lanes_oe) begin
			rx_n++;
			rx_w = {rx_w[13:0], serial_lanes_out};
		end
		b_lclk <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	// Display end: one frame in, replay checked while it stands, reply read back
	task automatic disp_frame(input logic rd, input logic sec, input logic cd,
		input logic [15:0] d);
		logic [21:0] f;
		logic [10:0] x;
		logic [10:0] s;
		int k;
		f = {2'h0, sec, !sec, cd, rd, rd ? 16'h0000 : d};
		x = {sec, !sec, cd, bus_style_strobe ? !rd : 1'b1, rd, !rd, 1'b1, 4'hf};
		rx_n = 0;
		cpu_data <= d;
		lane_tick(2'h0);
		for (k = 0; k < 11; k++)
			lane_tick(f[21 - 2 * k -: 2]);
		s = {primary_select_n_out, secondary_select_n_out, cmd_data_out,
			multi_fn_zero_out, multi_fn_one_out, data_oe, link_sleep_n_out,
			primary_select_n_oe, secondary_select_n_oe, cmd_data_oe, multi_fn_one_oe};
		check(s, x);
		if (!rd)
			check(data_out, d);
		repeat (12) lane_tick(2'h3);
		check(rx_n, rd ? 9 : 0);
		if (rd)
			check(rx_w, d);
	endtask

	// Watchdog well past the longest expected run
	initial begin
		#(40 * 20000);
		err_total++;
		finish_test();
	end

	// Main sequence: both styles on the host end, sleep, then the display end
	initial begin
		int k;
		int n;
		logic last;
		void'($urandom(32'h304df657));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		for (k = 0; k < 2; k++) begin
			bus_style_strobe <= !k[0];
			multi_fn_zero_in <= !k[0];
			repeat (6) @(posedge clk);
			for (n = 0; n < 4; n++)
				cpu_write(n[0], n[1], 16'($urandom));
			cpu_read(k[0]);
		end
		link_sleep_n_in <= 1'b0;
		repeat (10) @(posedge clk);
		check({serial_lanes_oe, serial_lane_clock_oe}, 2'h0);
		n = p_frames;
		cpu_cycle(1'b0, 1'b0, 1'b1, 16'h1234, 1'b0);
		repeat (300) @(posedge clk);
		check(p_frames - n, 0);
		link_sleep_n_in <= 1'b1;
		repeat (10) @(posedge clk);
		check(serial_lane_clock_oe, 1'b1);
		// Display end needs a fresh reset, the role being a strap
		rst <= 1'b1;
		role_host <= 1'b0;
		bus_style_strobe <= 1'b0;
		synth_cfg <= 3'h1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (100) @(posedge clk);
		check({link_sleep_n_oe, link_sleep_n_out, read_ready_irq}, 3'h4);
		check({multi_fn_zero_oe, multi_fn_zero_out, ref_clk_oe}, 3'h7);
		n = 0;
		last = ref_clk_out;
		for (k = 0; k < 80; k++) begin
			@(posedge clk);
			if (ref_clk_out !== last)
				n++;
			last = ref_clk_out;
		end
		check(n, 40);
		disp_frame(1'b0, 1'b0, 1'b1, 16'($urandom));
		disp_frame(1'b1, 1'b1, 1'b0, 16'($urandom));
		bus_style_strobe <= 1'b1;
		repeat (8) @(posedge clk);
		check({multi_fn_zero_out, multi_fn_one_out, primary_select_n_out}, 3'h7);
		disp_frame(1'b1, 1'b0, 1'b1, 16'($urandom));
		disp_frame(1'b0, 1'b1, 1'b0, 16'($urandom));
		finish_test();
	end
endmodule
